// [include/switch_bank_pkg.sv]
package switch_bank_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_INHIBIT = 8'h00;
   localparam logic [7:0] OFS_INTERACT = 8'h04;
   localparam logic [7:0] OFS_LATCH = 8'h08;
   localparam logic [7:0] OFS_CLEAR = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   localparam int INHIBIT_W = 7;
   localparam int INTERACT_W = 6;
   localparam int LED_N = 8;

   // reset values
   localparam logic [6:0] INHIBIT_RST = 7'h78;
   localparam logic [5:0] INTERACT_RST = 6'h00;
   localparam logic [7:0] LATCH_RST = 8'h00;

   // stage inhibit switch positions
   localparam int INH_HIGH_OC = 0;
   localparam int INH_INST_OC = 1;
   localparam int INH_HIGH_EF = 2;
   localparam int INH_PHASE_DISC = 3;
   localparam int INH_THERMAL = 4;
   localparam int INH_ARC = 5;
   localparam int INH_LIGHT = 6;

   // stage interaction switch positions
   localparam int IA_DOUBLE_HIGH_OC = 0;
   localparam int IA_INV_BY_HIGH_OC = 1;
   localparam int IA_INV_BY_INST_OC = 2;
   localparam int IA_DOUBLE_HIGH_EF = 3;
   localparam int IA_EF_INV_BY_HIGH_EF = 4;
   localparam int IA_LIGHT_BY_ARC = 5;

   // clear control positions
   localparam int CLR_DI_EN = 0;
   localparam int CLR_SERIAL_CMD = 1;

   // status positions
   localparam int ST_LIGHT = 8;
   localparam int ST_CLEARING = 9;

   typedef struct packed {
      logic highOcStart;
      logic instOcStart;
      logic highEfStart;
      logic arcTrip;
      logic lightReq;
      logic inrush;
   } stage_in_t;

   typedef struct packed {
      logic highOcEn;
      logic instOcEn;
      logic highEfEn;
      logic phaseDiscEn;
      logic thermalEn;
      logic arcEn;
      logic lightOut;
      logic highOcDouble;
      logic highEfDouble;
      logic lowOcInvInhibit;
      logic lowEfInvInhibit;
   } stage_ctl_t;
endpackage

// [core/led_latch.sv]
module led_latch #(
   parameter int N = 8
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [N-1:0] src,
   input wire logic [N-1:0] latchSel,
   input wire logic clear,
   output logic [N-1:0] led
);
   // an active source wins over a clear in the same cycle
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         led <= '0;
      end else begin
         led <= src | (latchSel & led & ~{N{clear}});
      end
   end
endmodule

// [core/protection_feature_switch_bank.sv]
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
module protection_feature_switch_bank (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire switch_bank_pkg::stage_in_t stageIn,
   input wire logic [switch_bank_pkg::LED_N-1:0] ledSrc,
   input wire logic panelClear,
   input wire logic digIn,
   output switch_bank_pkg::stage_ctl_t stageCtl,
   output logic [switch_bank_pkg::LED_N-1:0] led
);
   import switch_bank_pkg::*;

   logic [INHIBIT_W-1:0] inhibit_r;
   logic [INTERACT_W-1:0] interact_r;
   logic [LED_N-1:0] latch_r;
   logic diClrEn_r;
   logic serialClr_r;
   logic wrPend_r;
   logic [7:0] wrAddr_r;
   logic [7:0] rdAddr_r;
   logic panelMeta_r;
   logic panelSync_r;
   logic digMeta_r;
   logic digSync_r;
   logic clearAny;
   logic addrPhase;

   function automatic logic isReg(input logic [7:0] a, input logic [7:0] ofs);
      isReg = (a == ofs);
   endfunction

   // zero-wait slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addrPhase = hsel && htrans[1] && hready;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= 8'h00;
         rdAddr_r <= 8'h00;
      end else if (hready) begin
         wrPend_r <= addrPhase && hwrite;
         wrAddr_r <= haddr[7:0];
         rdAddr_r <= (addrPhase && !hwrite) ? haddr[7:0] : 8'hff;
      end
   end

   // switch groups, written in the data phase
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         inhibit_r <= INHIBIT_RST;
         interact_r <= INTERACT_RST;
         latch_r <= LATCH_RST;
      end else if (wrPend_r) begin
         if (isReg(wrAddr_r, OFS_INHIBIT)) begin
            inhibit_r <= hwdata[INHIBIT_W-1:0];
         end
         if (isReg(wrAddr_r, OFS_INTERACT)) begin
            interact_r <= hwdata[INTERACT_W-1:0];
         end
         if (isReg(wrAddr_r, OFS_LATCH)) begin
            latch_r <= hwdata[LED_N-1:0];
         end
      end
   end

   // serial clear command is a self-clearing pulse
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         diClrEn_r <= 1'b0;
         serialClr_r <= 1'b0;
      end else begin
         serialClr_r <= wrPend_r && isReg(wrAddr_r, OFS_CLEAR) && hwdata[CLR_SERIAL_CMD];
         if (wrPend_r && isReg(wrAddr_r, OFS_CLEAR)) begin
            diClrEn_r <= hwdata[CLR_DI_EN];
         end
      end
   end

   // pins cross into ref_clk through two flops
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         panelMeta_r <= 1'b0;
         panelSync_r <= 1'b0;
         digMeta_r <= 1'b0;
         digSync_r <= 1'b0;
      end else begin
         panelMeta_r <= panelClear;
         panelSync_r <= panelMeta_r;
         digMeta_r <= digIn;
         digSync_r <= digMeta_r;
      end
   end

   // level clear: a held input keeps latched leds dark
   assign clearAny = panelSync_r || serialClr_r || (digSync_r && diClrEn_r);

   // read mux from flops; a read right after a write sees the new value
   always_comb begin
      hrdata = 32'h0000_0000;
      case (rdAddr_r)
         OFS_INHIBIT: hrdata[INHIBIT_W-1:0] = inhibit_r;
         OFS_INTERACT: hrdata[INTERACT_W-1:0] = interact_r;
         OFS_LATCH: hrdata[LED_N-1:0] = latch_r;
         OFS_CLEAR: hrdata[CLR_DI_EN] = diClrEn_r;
         OFS_STATUS: begin
            hrdata[LED_N-1:0] = led;
            hrdata[ST_LIGHT] = stageCtl.lightOut;
            hrdata[ST_CLEARING] = clearAny;
         end
         default: hrdata = 32'h0000_0000;
      endcase
   end

   // stage enables from the inhibit group
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stageCtl.highOcEn <= 1'b0;
         stageCtl.instOcEn <= 1'b0;
         stageCtl.highEfEn <= 1'b0;
         stageCtl.phaseDiscEn <= 1'b0;
         stageCtl.thermalEn <= 1'b0;
         stageCtl.arcEn <= 1'b0;
      end else begin
         stageCtl.highOcEn <= !inhibit_r[INH_HIGH_OC];
         stageCtl.instOcEn <= !inhibit_r[INH_INST_OC];
         stageCtl.highEfEn <= !inhibit_r[INH_HIGH_EF];
         stageCtl.phaseDiscEn <= !inhibit_r[INH_PHASE_DISC];
         stageCtl.thermalEn <= !inhibit_r[INH_THERMAL];
         stageCtl.arcEn <= !inhibit_r[INH_ARC];
      end
   end

   // light output: inhibit wins, arc trip may block
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stageCtl.lightOut <= 1'b0;
      end else begin
         stageCtl.lightOut <= stageIn.lightReq && !inhibit_r[INH_LIGHT]
            && !(interact_r[IA_LIGHT_BY_ARC] && stageIn.arcTrip);
      end
   end

   // interaction between stages
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stageCtl.highOcDouble <= 1'b0;
         stageCtl.highEfDouble <= 1'b0;
         stageCtl.lowOcInvInhibit <= 1'b0;
         stageCtl.lowEfInvInhibit <= 1'b0;
      end else begin
         stageCtl.highOcDouble <= interact_r[IA_DOUBLE_HIGH_OC] && stageIn.inrush;
         // doubling the earth fault stage can mask real faults during inrush
         stageCtl.highEfDouble <= interact_r[IA_DOUBLE_HIGH_EF] && stageIn.inrush;
         stageCtl.lowOcInvInhibit <=
            (interact_r[IA_INV_BY_HIGH_OC] && stageIn.highOcStart)
            || (interact_r[IA_INV_BY_INST_OC] && stageIn.instOcStart);
         stageCtl.lowEfInvInhibit <=
            interact_r[IA_EF_INV_BY_HIGH_EF] && stageIn.highEfStart;
      end
   end

   led_latch #(
      .N(LED_N)
   ) ledLatch (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .src(ledSrc),
      .latchSel(latch_r),
      .clear(clearAny),
      .led(led)
   );

   inhibit_high_oc_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !$past(sys_rst) |-> stageCtl.highOcEn == !$past(inhibit_r[INH_HIGH_OC]))
      else $error("high overcurrent enable does not follow its inhibit switch");

   inhibit_arc_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !$past(sys_rst) && $past(inhibit_r[INH_ARC]) |-> !stageCtl.arcEn)
      else $error("arc stage enabled while inhibited");

   reset_inhibit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $past(sys_rst) |-> inhibit_r == INHIBIT_RST)
      else $error("inhibit group wrong after reset");

   light_inhibit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $past(inhibit_r[INH_LIGHT]) |-> !stageCtl.lightOut)
      else $error("light output active while inhibited");

   inrush_double_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !$past(sys_rst) |-> stageCtl.highEfDouble
         == ($past(interact_r[IA_DOUBLE_HIGH_EF]) && $past(stageIn.inrush)))
      else $error("earth fault doubling wrong");

   oc_inverse_block_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $past(interact_r[IA_INV_BY_INST_OC]) && $past(stageIn.instOcStart)
         |-> stageCtl.lowOcInvInhibit)
      else $error("instantaneous start did not block inverse time");

   ef_inverse_block_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !$past(sys_rst) && !$past(interact_r[IA_EF_INV_BY_HIGH_EF]) |-> !stageCtl.lowEfInvInhibit)
      else $error("earth fault inverse time blocked with switch off");

   arc_light_block_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $past(interact_r[IA_LIGHT_BY_ARC]) && $past(stageIn.arcTrip) |-> !stageCtl.lightOut)
      else $error("light output not blocked by arc trip");

   led_follow_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !$past(sys_rst) && $past(latch_r) == '0 |-> led == $past(ledSrc))
      else $error("unlatched led does not follow its source");

   led_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !$past(clearAny) |-> (led & $past(latch_r) & $past(led)) == ($past(latch_r) & $past(led)))
      else $error("latched led went dark without a clear");

   led_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !$past(sys_rst) && $past(clearAny) |-> led == $past(ledSrc))
      else $error("clear did not drop latched leds");

   di_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $past(digIn, 2) && diClrEn_r && $past(diClrEn_r) |-> clearAny)
      else $error("routed digital input did not clear");

   group_reset_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $past(sys_rst) |-> interact_r == '0 && latch_r == '0)
      else $error("second or third group not zero after reset");

   switch_take_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      wrPend_r && isReg(wrAddr_r, OFS_LATCH) |-> ##1 latch_r == $past(hwdata[LED_N-1:0]))
      else $error("latch switch write not taken next cycle");
endmodule

// [bench/protection_feature_switch_bank_test.sv]
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
   $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end

module protection_feature_switch_bank_test;
   timeunit 1ns;
   timeprecision 100ps;
   import switch_bank_pkg::*;

   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = '0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   stage_in_t stageIn = '0;
   logic [LED_N-1:0] ledSrc = '0;
   logic panelClear = 1'b0;
   logic digIn = 1'b0;
   stage_ctl_t stageCtl;
   logic [LED_N-1:0] led;
   logic [31:0] rdVal;
   logic [6:0] enVec;
   logic [4:0] iaVec;
   logic [4:0] iaExp;
   int fails = 0;
   int checks_done = 0;

   always #10 ref_clk = ~ref_clk;

   assign enVec = {stageCtl.lightOut, stageCtl.arcEn, stageCtl.thermalEn, stageCtl.phaseDiscEn,
                   stageCtl.highEfEn, stageCtl.instOcEn, stageCtl.highOcEn};
   assign iaVec = {stageCtl.highOcDouble, stageCtl.highEfDouble, stageCtl.lowOcInvInhibit,
                   stageCtl.lowEfInvInhibit, stageCtl.lightOut};

   protection_feature_switch_bank u_protection_feature_switch_bank (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .stageIn(stageIn),
      .ledSrc(ledSrc), .panelClear(panelClear), .digIn(digIn), .stageCtl(stageCtl),
      .led(led)
   );

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // bounded wait for hready, sampled at the rising edge
   task automatic waitReady();
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         fails++;
         end_sim();
      end
   endtask

   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      hsize <= 3'b010;
      waitReady();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      waitReady();
      rd = hrdata;
      `CHK("hresp", 1'b0, hresp)
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, rdVal);
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0, rdVal);
      `CHK("register read", e, rdVal)
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   initial begin
      settle(16);
      sys_rst <= 1'b0;
      settle(2);
      `CHK("reset enables", 7'h07, enVec)
      rdChk(OFS_INHIBIT, 32'h78);
      rdChk(OFS_INTERACT, 32'h0);
      rdChk(OFS_LATCH, 32'h0);
      rdChk(8'h20, 32'h0);
      wr(8'h20, 32'hffff_ffff);
      rdChk(8'h20, 32'h0);
      wr(OFS_INHIBIT, 32'hffff_ffff);
      rdChk(OFS_INHIBIT, 32'h7f);
      // each inhibit switch alone, light requested
      stageIn <= 6'b000010;
      for (int i = 0; i < 7; i++) begin
         wr(OFS_INHIBIT, 32'h1 << i);
         settle(2);
         `CHK("inhibit", ~(7'h01 << i), enVec)
      end
      wr(OFS_INHIBIT, 32'h0);
      // every interaction setting against every start and inrush pattern
      for (int s = 0; s < 64; s++) begin
         wr(OFS_INTERACT, s);
         for (int j = 0; j < 16; j++) begin
            stageIn <= {j[0], j[1], j[2], 1'b1, 1'b1, j[3]};
            settle(2);
            iaExp = {s[0] & j[3], s[3] & j[3], (s[1] & j[0]) | (s[2] & j[1]), s[4] & j[2], ~s[5]};
            `CHK("interaction", iaExp, iaVec)
         end
      end
      rdChk(OFS_INTERACT, 32'h3f);
      // leds: upper half latched
      wr(OFS_LATCH, 32'hf0);
      rdChk(OFS_LATCH, 32'hf0);
      ledSrc <= 8'hff;
      settle(2);
      `CHK("led set", 8'hff, led)
      ledSrc <= 8'h00;
      settle(6);
      `CHK("led hold", 8'hf0, led)
      rdChk(OFS_STATUS, 32'hf0);
      panelClear <= 1'b1;
      settle(5);
      `CHK("panel clear", 8'h00, led)
      panelClear <= 1'b0;
      ledSrc <= 8'h5a;
      settle(2);
      ledSrc <= 8'h00;
      settle(4);
      `CHK("led relatch", 8'h50, led)
      wr(OFS_CLEAR, 32'h2);
      settle(3);
      `CHK("serial clear", 8'h00, led)
      ledSrc <= 8'hf0;
      settle(2);
      ledSrc <= 8'h00;
      digIn <= 1'b1;
      settle(6);
      // digital input without its routing switch must not clear
      `CHK("di not routed", 8'hf0, led)
      wr(OFS_CLEAR, 32'h1);
      settle(4);
      `CHK("di clear", 8'h00, led)
      rdChk(OFS_CLEAR, 32'h1);
      rdChk(OFS_STATUS, 32'h200);
      digIn <= 1'b0;
      settle(4);
      end_sim();
   end
endmodule
